// >>> src/iosle_top.sv
`timescale 1ns/1ps
// Terminal status LED encoder for the I/O check item.
module iosle_top #(
  parameter int unsigned BLINK_HALF_CYC = iosle_pkg::BLINK_HALF_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       forward_run_input,
  input  wire logic       reverse_run_input,
  input  wire logic [4:0] general_input,
  input  wire logic [2:0] transistor_output,
  input  wire logic       aux_relay_contact,
  input  wire logic       alarm_relay_contact,
  input  wire logic       comm_control,
  input  wire logic [15:0] comm_command_word,
  input  wire logic       key_up,
  input  wire logic       key_down,
  input  wire logic       show_output_word,
  output logic [7:0]      digit1_seg,
  output logic [7:0]      digit2_seg,
  output logic [7:0]      digit3_seg,
  output logic [7:0]      digit4_seg,
  output logic            hex_view
);

  // Pin inputs: two flip-flops each before any use.
  localparam int NPIN = 17;
  logic [NPIN-1:0] pin_s1_reg;
  logic [NPIN-1:0] pin_s2_reg;
  wire  [NPIN-1:0] pin_raw = {key_down, key_up, alarm_relay_contact,
                              aux_relay_contact, transistor_output,
                              general_input, reverse_run_input,
                              forward_run_input, 3'h0};

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end
    else
    begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Synchronised terminal levels, one meaning closed/on.
  wire       t_fwd   = pin_s2_reg[3];
  wire       t_rev   = pin_s2_reg[4];
  wire [4:0] t_gen   = pin_s2_reg[9:5];
  wire [2:0] t_tr    = pin_s2_reg[12:10];
  wire       t_aux   = pin_s2_reg[13];
  wire       t_alm   = pin_s2_reg[14];
  wire       k_up    = pin_s2_reg[15];
  wire       k_down  = pin_s2_reg[16];

  // Terminal input word; unassigned bits stay zero.
  logic [15:0] term_in_word;
  always_comb
  begin
    term_in_word = 16'h0000;
    term_in_word[iosle_pkg::IN_FWD_BIT] = t_fwd;
    term_in_word[iosle_pkg::IN_REV_BIT] = t_rev;
    term_in_word[iosle_pkg::IN_GEN_LSB +: iosle_pkg::IN_GEN_NUM] =
      t_gen;
  end

  // Comm word taken as is, positive logic; keep only assigned bits.
  wire [15:0] comm_mask  = 16'h81FF;
  wire [15:0] comm_word  = comm_command_word & comm_mask;
  wire [15:0] in_word    = comm_control ? comm_word : term_in_word;

  // Output word.
  logic [15:0] out_word;
  always_comb
  begin
    out_word = 16'h0000;
    out_word[iosle_pkg::OUT_TR_LSB +: 3]     = t_tr;
    out_word[iosle_pkg::OUT_AUX_BIT]         = t_aux;
    out_word[iosle_pkg::OUT_ALM_BIT]         = t_alm;
  end

  // View toggle once in each cycle with a rising edge of up or down key or both.
  logic k_up_d_reg;
  logic k_down_d_reg;
  iosle_pkg::iosle_view_type view_reg;
  iosle_pkg::iosle_view_type view_next;
  wire key_hit = (k_up & ~k_up_d_reg) | (k_down & ~k_down_d_reg);

  always_comb
  begin
    case (view_reg)
      iosle_pkg::IOSLE_VIEW_SEG:
        view_next = key_hit ? iosle_pkg::IOSLE_VIEW_HEX
                            : iosle_pkg::IOSLE_VIEW_SEG;
      iosle_pkg::IOSLE_VIEW_HEX:
        view_next = key_hit ? iosle_pkg::IOSLE_VIEW_SEG
                            : iosle_pkg::IOSLE_VIEW_HEX;
      default:
        view_next = iosle_pkg::IOSLE_VIEW_SEG;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      k_up_d_reg   <= 1'b0;
      k_down_d_reg <= 1'b0;
      view_reg     <= iosle_pkg::IOSLE_VIEW_SEG;
    end
    else
    begin
      k_up_d_reg   <= k_up;
      k_down_d_reg <= k_down;
      view_reg     <= view_next;
    end
  end

  // Blink phase source.
  logic blink_phase;
  iosle_blink #(
    .HALF_CYC (BLINK_HALF_CYC)
  ) u_blink (
    .clk_sys (clk_sys),
    .srst    (srst),
    .phase   (blink_phase)
  );

  // Segment view patterns.
  wire [7:0] seg_d1 = {1'b0, in_word[6:0]};
  wire [7:0] seg_d2 = comm_control ?
    {in_word[iosle_pkg::IN_RST_BIT], in_word[iosle_pkg::IN_XR_BIT],
     in_word[iosle_pkg::IN_XF_BIT], 5'h00} : 8'h00;
  wire [7:0] seg_d3 = {3'h0, t_aux, 1'b0, t_tr};
  wire [7:0] seg_d4 = {7'h00, t_alm};
  wire       all_off = (in_word == 16'h0000);
  wire [7:0] blink_g = blink_phase ? 8'h40 : 8'h00;

  // Hex view words: which word is shown is a plain select input.
  wire [15:0] hex_word = show_output_word ? out_word : in_word;

  // Final digit selection.
  wire seg_mode = (view_reg == iosle_pkg::IOSLE_VIEW_SEG);
  wire [7:0] d1_next = seg_mode ? (all_off ? blink_g : seg_d1)
                     : iosle_pkg::hex_glyph(hex_word[3:0]);
  wire [7:0] d2_next = seg_mode ? (all_off ? blink_g : seg_d2)
                     : iosle_pkg::hex_glyph(hex_word[7:4]);
  wire [7:0] d3_next = seg_mode ? (all_off ? blink_g : seg_d3)
                     : iosle_pkg::hex_glyph(hex_word[11:8]);
  wire [7:0] d4_next = seg_mode ? (all_off ? blink_g : seg_d4)
                     : iosle_pkg::hex_glyph(hex_word[15:12]);

  // Registered outputs.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      digit1_seg <= iosle_pkg::SEG_RESET;
      digit2_seg <= iosle_pkg::SEG_RESET;
      digit3_seg <= iosle_pkg::SEG_RESET;
      digit4_seg <= iosle_pkg::SEG_RESET;
      hex_view   <= 1'b0;
    end
    else
    begin
      digit1_seg <= d1_next;
      digit2_seg <= d2_next;
      digit3_seg <= d3_next;
      digit4_seg <= d4_next;
      hex_view   <= ~seg_mode;
    end
  end

endmodule

// >>> src/iosle_pkg.sv
// How it works
// - Digit 1 segments a..g show forward, reverse, general inputs 1..5 closed.
// - Digit 3 a,b,c show transistor outputs 1..3; segment e shows aux relay.
// - Digit 4 segment a lit while alarm relay common-to-open contact closed.
// - Segment view with all inputs off blinks segment g on all four digits.
// - Digit 2 f,g,dp show comm forward, reverse, reset; dark under terminals.
// - Hex view shows 16-bit word as four digits, unassigned bits zero.
// - Input word bit 0 is forward run, bit 1 reverse run.
// - Input word bits 2..6 hold general inputs 1..5 ascending.
// - Input bit reads one when terminal shorted, zero when open.
// - Output word bits 0..2 hold transistor outputs 1..3, one when shorted.
// - Output bit 8 is one while alarm relay normally-open contact closed.
// - Output bit 4 reflects aux relay contact pair closed.
// - Comm control takes inputs from command word, positive logic, no inversion.
// - Up/down key presses toggle between segment and hexadecimal view.
package iosle_pkg;

  // Clock rate and blink half period.
  localparam int unsigned CLK_HZ         = 125000000;
  localparam int unsigned BLINK_HALF_MS  = 500;
  localparam int unsigned BLINK_HALF_CYC =
    (CLK_HZ / 1000) * BLINK_HALF_MS;

  // Input status word bit positions.
  localparam int IN_FWD_BIT   = 0;
  localparam int IN_REV_BIT   = 1;
  localparam int IN_GEN_LSB   = 2;
  localparam int IN_GEN_NUM   = 5;
  localparam int IN_XF_BIT    = 7;
  localparam int IN_XR_BIT    = 8;
  localparam int IN_RST_BIT   = 15;

  // Output status word bit positions.
  localparam int OUT_TR_LSB   = 0;
  localparam int OUT_AUX_BIT  = 4;
  localparam int OUT_ALM_BIT  = 8;

  // Segment vector bit positions, a in bit 0 up to dp in bit 7.
  localparam int SEG_A  = 0;
  localparam int SEG_B  = 1;
  localparam int SEG_C  = 2;
  localparam int SEG_E  = 4;
  localparam int SEG_F  = 5;
  localparam int SEG_G  = 6;
  localparam int SEG_DP = 7;

  // Reset values.
  localparam logic [7:0] SEG_RESET  = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  // View selection states.
  typedef enum logic [0:0]
  {
    IOSLE_VIEW_SEG = 1'b0,
    IOSLE_VIEW_HEX = 1'b1
  } iosle_view_type;

  // Hex nibble to segments; a in bit 0, g in bit 6, dp dark.
  function automatic logic [7:0] hex_glyph(input logic [3:0] nib);
    case (nib)
      4'h0: hex_glyph = 8'h3F;
      4'h1: hex_glyph = 8'h06;
      4'h2: hex_glyph = 8'h5B;
      4'h3: hex_glyph = 8'h4F;
      4'h4: hex_glyph = 8'h66;
      4'h5: hex_glyph = 8'h6D;
      4'h6: hex_glyph = 8'h7D;
      4'h7: hex_glyph = 8'h07;
      4'h8: hex_glyph = 8'h7F;
      4'h9: hex_glyph = 8'h6F;
      4'hA: hex_glyph = 8'h77;
      4'hB: hex_glyph = 8'h7C;
      4'hC: hex_glyph = 8'h39;
      4'hD: hex_glyph = 8'h5E;
      4'hE: hex_glyph = 8'h79;
      default: hex_glyph = 8'h71;
    endcase
  endfunction

endpackage

// >>> src/iosle_blink.sv
`timescale 1ns/1ps
// Free-running blink phase: toggles every HALF_CYC clock cycles.
module iosle_blink #(
  parameter int unsigned HALF_CYC = iosle_pkg::BLINK_HALF_CYC
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  output logic      phase
);

  logic [31:0] cnt_reg;
  logic        phase_reg;
  wire         wrap = (cnt_reg == 32'(HALF_CYC - 1));

  // Period counter derived from the system clock.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cnt_reg   <= 32'h0000_0000;
      phase_reg <= 1'b0;
    end
    else if (wrap)
    begin
      cnt_reg   <= 32'h0000_0000;
      phase_reg <= ~phase_reg;
    end
    else
    begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  assign phase = phase_reg;

endmodule

// >>> tb/iosle_monitor.sv
`timescale 1ns/1ps
// Port checker for the status encoder.
module iosle_monitor #(
  parameter int unsigned BLINK_HALF_CYC = 4
) (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        forward_run_input,
  input wire logic        reverse_run_input,
  input wire logic [4:0]  general_input,
  input wire logic [2:0]  transistor_output,
  input wire logic        aux_relay_contact,
  input wire logic        alarm_relay_contact,
  input wire logic        comm_control,
  input wire logic [15:0] comm_command_word,
  input wire logic        key_up,
  input wire logic        key_down,
  input wire logic        show_output_word,
  input wire logic [7:0]  digit1_seg,
  input wire logic [7:0]  digit2_seg,
  input wire logic [7:0]  digit3_seg,
  input wire logic [7:0]  digit4_seg,
  input wire logic        hex_view
);
  logic [2:0]  up_reg;
  logic [6:0]  pins;
  logic [6:0]  pins_d1_reg;
  logic [6:0]  pins_d2_reg;
  logic [15:0] w;
  logic        ok;
  logic        live;
  // Input pins delayed as the design's two-stage synchroniser sees them.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pins_d1_reg <= 7'h00;
      pins_d2_reg <= 7'h00;
    end
    else
    begin
      pins_d1_reg <= pins;
      pins_d2_reg <= pins_d1_reg;
    end
  end
  // High while the effective input word is not all open, so no blink.
  assign live = comm_control ? ((w & 16'h81FF) != 16'h0000)
                             : (pins_d2_reg != 7'h00);
  // Counts edges after reset, since the pin paths need four to settle.
  always_ff @(posedge clk_sys)
    if (srst)
      up_reg <= 3'h0;
    else if (!ok)
      up_reg <= up_reg + 3'h1;
  // Shorthands for the properties.
  assign ok = up_reg == 3'h4;
  assign w = comm_command_word;
  assign pins = {general_input, reverse_run_input, forward_run_input};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  chk_seg_terms: assert property ((ok && !comm_control
    && $past(pins, 2) != 7'h00 ##1 !hex_view) |-> digit2_seg == 8'h00
    && digit1_seg == {1'b0, $past(pins, 3)}) else $error("segment view");
  chk_seg_relays: assert property ((ok && live ##1 !hex_view) |->
    digit3_seg[5:0] == {1'b0, $past(aux_relay_contact, 3), 1'b0,
    $past(transistor_output, 3)} && digit4_seg[0] ==
    $past(alarm_relay_contact, 3)) else $error("relay segments");
  chk_seg_comm: assert property ((ok && comm_control
    && w[6:0] != 7'h00 ##1 !hex_view) |-> digit1_seg == {1'b0, $past(w[6:0])}
    && digit2_seg == {$past(w[15]), $past(w[8:7]), 5'h00})
    else $error("command segments");
  chk_hex_comm: assert property ((ok && comm_control
    && !show_output_word ##1 hex_view) |->
    digit4_seg == ($past(w[15]) ? 8'h7F : 8'h3F)
    && digit3_seg == ($past(w[8]) ? 8'h06 : 8'h3F)) else $error("hex word");
  chk_hex_outputs: assert property ((ok && show_output_word
    ##1 hex_view) |-> digit4_seg == 8'h3F && digit3_seg ==
    ($past(alarm_relay_contact, 3) ? 8'h06 : 8'h3F)) else $error("out hex");
  chk_view_toggle: assert property (ok
    && ($rose(key_up) || $rose(key_down))
    |-> ##4 hex_view != $past(hex_view, 4)) else $error("view");
  chk_blink_g: assert property (
    (ok && comm_control && !hex_view && w == 16'h0000)[*8] |=>
    digit1_seg[6] != $past(digit1_seg[6], BLINK_HALF_CYC)
    && digit1_seg[5:0] == 6'h00 && digit2_seg == digit1_seg
    && digit4_seg[6] == digit1_seg[6]) else $error("blink");
  chk_reset_dark: assert property (disable iff (1'b0) srst |=>
    {digit1_seg, digit2_seg, digit3_seg, digit4_seg, hex_view} == 33'h0)
    else $error("reset");
  // Main scenarios reached.
  cov_blink: cover property ((comm_control && !hex_view && w == 16'h0)[*8]);
  cov_hex_cmd: cover property (comm_control && hex_view);
  cov_hex_out: cover property (hex_view && show_output_word);
endmodule
bind iosle_top iosle_monitor #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) mon (.*);

// >>> tb/iosle_partner.sv
`timescale 1ns/1ps
// Terminal circuits; a closed contact reads high.
module iosle_partner (
  input wire logic        clk_sys,
  input wire logic [11:0] state,
  output logic     [11:0] pins = 12'h000
);
  // Contacts change just after the clock edge.
  always @(posedge clk_sys)
    pins <= #1 state;
endmodule

// >>> tb/tb_io_status_led_encoder.sv
`timescale 1ns/1ps
module tb_io_status_led_encoder;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        forward_run_input;
  logic        reverse_run_input;
  logic [4:0]  general_input;
  logic [2:0]  transistor_output;
  logic        aux_relay_contact;
  logic        alarm_relay_contact;
  logic        comm_control = 1'b0;
  logic [15:0] comm_command_word = 16'h0000;
  logic        key_up = 1'b0;
  logic        key_down = 1'b0;
  logic        show_output_word = 1'b0;
  logic [7:0]  digit1_seg;
  logic [7:0]  digit2_seg;
  logic [7:0]  digit3_seg;
  logic [7:0]  digit4_seg;
  logic        hex_view;
  logic [11:0] term_state = 12'h000;
  logic [11:0] pins;
  logic        view = 1'b0;
  logic [7:0]  rnd = 8'h2C;
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n;
  logic [7:0]  glyph [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D,
    8'h7D, 8'h07, 8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
  // Design, terminal model and pin fan-out.
  iosle_top #(.BLINK_HALF_CYC(4)) DUT (.*);
  iosle_partner partner (.clk_sys(clk_sys), .state(term_state), .pins(pins));
  assign {alarm_relay_contact, aux_relay_contact, transistor_output,
    general_input, reverse_run_input, forward_run_input} = pins;
  // Clock of 8 ns.
  always #4 clk_sys = ~clk_sys;
  // Next stimulus value.
  function automatic logic [7:0] lfsr(input logic [7:0] r);
    lfsr = {r[6:0], r[7] ^ r[5] ^ r[4] ^ r[3]};
  endfunction
  // Expected digits in the bench's view, unassigned bits cleared.
  function automatic logic [31:0] want(input logic [11:0] s);
    logic [15:0] x;
    x = comm_control ? comm_command_word & 16'h81FF : {9'h000, s[6:0]};
    if (view && show_output_word)
      x = {7'h00, s[11], 3'h0, s[10], 1'b0, s[9:7]};
    if (view)
      want = {glyph[x[15:12]], glyph[x[11:8]], glyph[x[7:4]], glyph[x[3:0]]};
    else
      want = {7'h00, s[11], 3'h0, s[10], 1'b0, s[9:7], x[15], x[8:7],
        5'h00, 1'b0, x[6:0]};
  endfunction
  // Waits k edges, then steps off the edge.
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // Counts a comparison and reports a difference.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One random case; segment view keeps some input closed.
  task automatic step(input logic comm);
    tick(1);
    rnd = lfsr(rnd);
    comm_command_word[15:8] = rnd;
    rnd = lfsr(rnd);
    comm_command_word[7:0] = rnd;
    rnd = lfsr(rnd);
    term_state = {rnd, rnd[7:4] ^ comm_command_word[3:0]};
    show_output_word = rnd[2];
    comm_control = comm;
    if (!view)
    begin
      term_state[6] |= ~|term_state[5:0];
      comm_command_word[6] |= ~|comm_command_word[5:0];
    end
    tick(5);
    check({digit4_seg, digit3_seg, digit2_seg, digit1_seg},
      want(term_state));
  endtask
  // Holds a key two cycles; the view toggles once.
  task automatic press(input logic up);
    tick(1);
    key_up = up;
    key_down = !up;
    tick(2);
    key_up = 1'b0;
    key_down = 1'b0;
    view = !view;
    tick(5);
    check(hex_view, view);
  endtask
  // Prints the counts and the verdict.
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      final_report();
    end
  end
  // Reset, random cases per mode and view, then the all-open blink.
  initial
  begin
    tick(4);
    srst = 1'b0;
    check({digit4_seg, digit3_seg, digit2_seg, digit1_seg}, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      if (m == 2)
        press(1'b1);
      repeat (12) step(m[0]);
    end
    press(1'b0);
    term_state = 12'h000;
    comm_command_word = 16'h0000;
    tick(6);
    n = 0;
    repeat (8)
    begin
      tick(1);
      n += digit1_seg[6];
    end
    check(n, 4);
    final_report();
  end
endmodule
